// file: ckirq_pkg.sv
package ckirq_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_IRQ_ENABLE_CMD  = 8'h00;
  localparam logic [7:0] ADDR_IRQ_DISABLE_CMD = 8'h04;
  localparam logic [7:0] ADDR_STATUS          = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK        = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_EVENT       = 8'h10;
  localparam logic [7:0] ADDR_PUMP_CURRENT    = 8'h14;
  localparam logic [7:0] ADDR_PLL_FIRST_CFG   = 8'h18;

  // Event and status bit positions
  localparam int BIT_OSC_STABLE  = 0;
  localparam int BIT_PLL_FIRST   = 1;
  localparam int BIT_PLL_SECOND  = 2;
  localparam int BIT_MCK_READY   = 3;
  localparam int BIT_SLOW_SEL    = 7;
  localparam int BIT_PROG_CLK0   = 8;
  localparam int BIT_PROG_CLK1   = 9;
  localparam logic [31:0] EVENT_BITS = 32'h0000_030F;

  // Charge pump field positions
  localparam int BIT_PUMP_FIRST  = 0;
  localparam int BIT_PUMP_SECOND = 16;

  // Lock wait count field of the first PLL configuration
  localparam int LOCK_WAIT_LSB   = 8;
  localparam int LOCK_WAIT_W     = 6;

  // Reset values
  localparam logic [31:0] MASK_RST    = 32'h0000_0000;
  localparam logic [31:0] EVENT_RST   = 32'h0000_0000;
  localparam logic [31:0] PLL_CFG_RST = 32'h0000_0000;
  localparam logic        PUMP_RST    = 1'b0;

  // Timing
  localparam int CLK_HZ      = 100_000_000;
  localparam int SLOW_CLK_HZ = 32_768;
  localparam int SLOW_DIV    = CLK_HZ / SLOW_CLK_HZ;

  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;
endpackage : ckirq_pkg

// file: ckirq_top.sv
`timescale 1ns/10ps
// Contract
// - Disable, status and mask registers share one layout: bit0 osc, bit1 PLL first, bit2 PLL second, bit3 master clock, bits 8 and 9 programmable clocks.
// - Writing the disable command clears mask bits written as one and leaves the others.
// - The oscillator flag reads one once the main oscillator is stable, zero before.
// - The first PLL lock flag reads zero until that PLL locks and one after.
// - The second PLL lock flag reads zero until that PLL locks and one after.
// - The master clock ready flag is one when the master clock is ready and zero otherwise.
// - Status bit 7 shows the slow clock source: zero internal RC, one external 32 kHz crystal.
// - Each programmable clock has a ready flag, one when ready and zero when not.
// - Reading the mask register returns the mask, one enabled and zero disabled.
// - Writing the enable command sets mask bits written as one; zeros do nothing.
// - After the first PLL configuration is written, its lock flag waits the programmed slow clock count plus one tick.
module ckirq_top #(
  parameter int SLOW_DIV_P = ckirq_pkg::SLOW_DIV
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [31:0] s_axi_araddr,
  // AXI4-Lite read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Clock generator conditions, asynchronous
  input  wire logic        osc_stable_in,
  input  wire logic        pll_second_lock_in,
  input  wire logic        master_clk_ready_in,
  input  wire logic        prog_clk0_ready_in,
  input  wire logic        prog_clk1_ready_in,
  input  wire logic        slow_osc_source_in,
  // Configuration outputs
  output logic             pump_current_first,
  output logic             pump_current_second,
  output logic [31:0]      pll_first_cfg,
  // Interrupt
  output logic             irq
);

  localparam int NSYNC = 6;
  localparam int LOCK_WAIT_W_L = ckirq_pkg::LOCK_WAIT_W;

  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] sync1_r;
  logic [NSYNC-1:0] sync2_r;
  logic [NSYNC-1:0] sync3_r;
  logic [NSYNC-1:0] clean_r;
  logic [31:0]      flags;
  logic [31:0]      mask_r;
  logic [31:0]      event_r;
  logic [LOCK_WAIT_W_L-1:0] wait_cnt_r;
  logic             wait_busy_r;
  logic             pll_first_lock_flag;
  logic [11:0]      slow_div_r;
  logic             slow_tick;
  logic             aw_have_r;
  logic             w_have_r;
  logic [7:0]       aw_addr_r;
  logic [31:0]      w_data_r;
  logic [3:0]       w_strb_r;
  logic [31:0]      w_bytes;
  logic             wr_fire;
  logic             rd_fire;
  logic             rd_hit;
  logic [31:0]      rd_word;

  // Pin conditions pass three flops; a change counts once stages two and three agree
  // A one-cycle glitch on a pin never reaches status or the event bits
  assign raw_in = {slow_osc_source_in, prog_clk1_ready_in, prog_clk0_ready_in,
                   master_clk_ready_in, pll_second_lock_in, osc_stable_in};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
          sync3_r[gi] <= 1'b0;
          clean_r[gi] <= 1'b0;
        end else begin
          sync1_r[gi] <= raw_in[gi];
          sync2_r[gi] <= sync1_r[gi];
          sync3_r[gi] <= sync2_r[gi];
          if (sync2_r[gi] == sync3_r[gi]) begin
            clean_r[gi] <= sync3_r[gi];
          end
        end
      end
    end
  endgenerate

  always_comb begin
    flags = 32'h0000_0000;
    flags[ckirq_pkg::BIT_OSC_STABLE] = clean_r[0];
    flags[ckirq_pkg::BIT_PLL_FIRST]  = pll_first_lock_flag;
    flags[ckirq_pkg::BIT_PLL_SECOND] = clean_r[1];
    flags[ckirq_pkg::BIT_MCK_READY]  = clean_r[2];
    flags[ckirq_pkg::BIT_PROG_CLK0]  = clean_r[3];
    flags[ckirq_pkg::BIT_PROG_CLK1]  = clean_r[4];
    flags[ckirq_pkg::BIT_SLOW_SEL]   = clean_r[5];
  end

  // Slow clock rate as an enable pulse
  // Free-running, so the first tick after a write lands 1 to SLOW_DIV_P cycles later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slow_div_r <= 12'h000;
    end else if (slow_div_r == 12'(SLOW_DIV_P - 1)) begin
      slow_div_r <= 12'h000;
    end else begin
      slow_div_r <= slow_div_r + 12'h001;
    end
  end
  assign slow_tick = (slow_div_r == 12'(SLOW_DIV_P - 1));

  // Write path: address and data taken in either order
  assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_r && !s_axi_bvalid;
  assign wr_fire       = aw_have_r && w_have_r && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      aw_addr_r <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_r <= 1'b1;
      if (s_axi_awaddr[31:8] != 24'h00_0000) begin
        // Out-of-window address parks on an unmapped code
        aw_addr_r <= 8'hFF;
      end else begin
        aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
      end
    end else if (wr_fire) begin
      aw_have_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_have_r <= 1'b0;
    end
  end

  // Lanes not strobed count as written zero
  assign w_bytes = w_data_r & {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};

  // Response stands until bready; address and data stay refused meanwhile
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= ckirq_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      case (aw_addr_r)
        ckirq_pkg::ADDR_IRQ_ENABLE_CMD, ckirq_pkg::ADDR_IRQ_DISABLE_CMD,
        ckirq_pkg::ADDR_STATUS, ckirq_pkg::ADDR_IRQ_MASK, ckirq_pkg::ADDR_IRQ_EVENT,
        ckirq_pkg::ADDR_PUMP_CURRENT, ckirq_pkg::ADDR_PLL_FIRST_CFG: begin
          s_axi_bresp <= ckirq_pkg::RESP_OKAY;
        end
        default: begin
          s_axi_bresp <= ckirq_pkg::RESP_DECERR;
        end
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Interrupt mask, set and cleared through command words only
  // Enable and disable sit at separate offsets, so one write never does both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_r <= ckirq_pkg::MASK_RST;
    end else if (wr_fire && aw_addr_r == ckirq_pkg::ADDR_IRQ_ENABLE_CMD) begin
      mask_r <= mask_r | (w_bytes & ckirq_pkg::EVENT_BITS);
    end else if (wr_fire && aw_addr_r == ckirq_pkg::ADDR_IRQ_DISABLE_CMD) begin
      mask_r <= mask_r & ~(w_bytes & ckirq_pkg::EVENT_BITS);
    end
  end

  // Charge pump current, write-only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pump_current_first  <= ckirq_pkg::PUMP_RST;
      pump_current_second <= ckirq_pkg::PUMP_RST;
    end else if (wr_fire && aw_addr_r == ckirq_pkg::ADDR_PUMP_CURRENT) begin
      if (w_strb_r[0]) begin
        pump_current_first <= w_data_r[ckirq_pkg::BIT_PUMP_FIRST];
      end
      // Stored as written; software is expected to keep it zero
      if (w_strb_r[2]) begin
        pump_current_second <= w_data_r[ckirq_pkg::BIT_PUMP_SECOND];
      end
    end
  end

  // First PLL configuration restarts the lock wait
  // Count N takes N+1 ticks; a rewrite drops the flag and starts again
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pll_first_cfg       <= ckirq_pkg::PLL_CFG_RST;
      wait_cnt_r          <= '0;
      wait_busy_r         <= 1'b0;
      pll_first_lock_flag <= 1'b0;
    end else if (wr_fire && aw_addr_r == ckirq_pkg::ADDR_PLL_FIRST_CFG) begin
      pll_first_cfg       <= w_bytes;
      wait_cnt_r          <= w_bytes[ckirq_pkg::LOCK_WAIT_LSB +: LOCK_WAIT_W_L];
      wait_busy_r         <= 1'b1;
      pll_first_lock_flag <= 1'b0;
    end else if (wait_busy_r && slow_tick) begin
      if (wait_cnt_r == '0) begin
        wait_busy_r         <= 1'b0;
        pll_first_lock_flag <= 1'b1;
      end else begin
        wait_cnt_r <= wait_cnt_r - LOCK_WAIT_W_L'(1);
      end
    end
  end

  // Read path
  // Upper address bits outside the window answer decode error with zero data
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire       = s_axi_arvalid && s_axi_arready;

  always_comb begin
    rd_hit  = 1'b1;
    rd_word = 32'h0000_0000;
    case ({s_axi_araddr[7:2], 2'b00})
      ckirq_pkg::ADDR_STATUS:        rd_word = flags;
      ckirq_pkg::ADDR_IRQ_MASK:      rd_word = mask_r;
      ckirq_pkg::ADDR_IRQ_EVENT:     rd_word = event_r;
      ckirq_pkg::ADDR_PLL_FIRST_CFG: rd_word = pll_first_cfg;
      ckirq_pkg::ADDR_IRQ_ENABLE_CMD, ckirq_pkg::ADDR_IRQ_DISABLE_CMD,
      ckirq_pkg::ADDR_PUMP_CURRENT:  rd_word = 32'h0000_0000;
      default:                       rd_hit  = 1'b0;
    endcase
    if (s_axi_araddr[31:8] != 24'h00_0000) begin
      rd_hit  = 1'b0;
      rd_word = 32'h0000_0000;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= ckirq_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_hit ? ckirq_pkg::RESP_OKAY : ckirq_pkg::RESP_DECERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Sticky events: re-set every cycle a flag stays high, so set beats the read clear
  // Only the event word clears on read; status reads have no side effect
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      event_r <= ckirq_pkg::EVENT_RST;
    end else if (rd_fire && rd_hit && {s_axi_araddr[7:2], 2'b00} == ckirq_pkg::ADDR_IRQ_EVENT) begin
      event_r <= flags & ckirq_pkg::EVENT_BITS;
    end else begin
      event_r <= event_r | (flags & ckirq_pkg::EVENT_BITS);
    end
  end

  // Level output: stays high until the event is read away or masked
  assign irq = |(event_r & mask_r);

endmodule : ckirq_top

// file: ckirq_checker.sv
`timescale 1ns/10ps
module ckirq_checker (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Conditions and outputs
  input wire logic        osc_stable_in,
  input wire logic        pll_second_lock_in,
  input wire logic        master_clk_ready_in,
  input wire logic        prog_clk0_ready_in,
  input wire logic        prog_clk1_ready_in,
  input wire logic        slow_osc_source_in,
  input wire logic [31:0] pll_first_cfg,
  input wire logic        irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [3:0] up_r;
  logic       wr_take;
  logic [9:0] cond;
  assign wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign cond = {prog_clk1_ready_in, prog_clk0_ready_in, slow_osc_source_in, 3'h0,
                 master_clk_ready_in, pll_second_lock_in, 1'b0, osc_stable_in};
  // Synchronisers restart at reset, so status is trusted only after settling
  always_ff @(posedge aclk) begin
    if (!aresetn)
      up_r <= 4'h0;
    else if (up_r != 4'hF)
      up_r <= up_r + 4'h1;
  end
  a_reset_quiet: assert property ($rose(aresetn) |-> !irq && !s_axi_bvalid && !s_axi_rvalid)
    else $error("busy after reset");
  a_write_answer: assert property (wr_take |-> ##2 s_axi_bvalid)
    else $error("no write response");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read response");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_read_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read valid stuck");
  a_disable_quiets: assert property (wr_take && s_axi_awaddr == 32'h4 &&
    (s_axi_wdata & 32'h30F) == 32'h30F |=> ##1 !irq) else $error("irq after disable all");
  a_cfg_follows: assert property (wr_take && s_axi_awaddr == 32'h18 |=>
    ##1 pll_first_cfg == $past(s_axi_wdata, 2)) else $error("pll config not stored");
  a_status_mirror: assert property ($stable(cond)[*6] ##0 (up_r == 4'hF && s_axi_arvalid &&
    s_axi_arready && s_axi_araddr == 32'h8) |=> (s_axi_rdata & 32'h3FD) == {22'h0, cond})
    else $error("status bits wrong");
endmodule : ckirq_checker

bind ckirq_top ckirq_checker u_chk (.*);

// file: ckirq_tb_top.sv
`timescale 1ns/10ps
module ckirq_tb_top;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, pll_first_cfg, v, m;
  logic        pump_current_first, pump_current_second;
  logic [5:0]  cin = 6'h00;
  wire         osc_stable_in       = cin[0];
  wire         pll_second_lock_in  = cin[1];
  wire         master_clk_ready_in = cin[2];
  wire         slow_osc_source_in  = cin[3];
  wire         prog_clk0_ready_in  = cin[4];
  wire         prog_clk1_ready_in  = cin[5];
  logic [65:0] rd_q[$];
  logic [1:0]  wr_q[$];
  logic [65:0] e;
  int          mismatches = 0;
  int          n_compared = 0;
  int          cyc = 0;

  ckirq_top #(.SLOW_DIV_P(4)) DUT (.*);

  always #5 aclk = ~aclk;

  task end_of_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  task cmp(input string name, input logic [31:0] x, input logic [31:0] got);
    n_compared++;
    if (x !== got) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, x, got);
    end
  endtask : cmp

  task wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
    wr_q.push_back(r);
    @(posedge aclk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask : wr

  task rd(input logic [31:0] a, input logic [31:0] x, input logic [31:0] k, input logic [1:0] r);
    rd_q.push_back({r, x & k, k});
    @(posedge aclk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask : rd

  // Scoreboard side: judges each answer as the handshake completes
  always @(posedge aclk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready) begin
      e = rd_q.pop_front();
      cmp("read data", e[63:32], s_axi_rdata & e[31:0]);
      cmp("read resp", {30'h0, e[65:64]}, {30'h0, s_axi_rresp});
    end
    if (s_axi_bvalid === 1'b1 && s_axi_bready)
      cmp("write resp", {30'h0, wr_q.pop_front()}, {30'h0, s_axi_bresp});
  end

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      end_of_test();
    end
  end

  initial begin
    v = $urandom(35081);
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    cmp("irq", 32'h0, {31'h0, irq});
    rd(32'h0C, 32'h0, ALL, 2'h0);
    rd(32'h14, 32'h0, ALL, 2'h0);
    rd(32'h40, 32'h0, ALL, 2'h3);
    wr(32'h40, ALL, 2'h3);
    wr(32'h0C, ALL, 2'h0);
    rd(32'h0C, 32'h0, ALL, 2'h0);
    $display("test reset_map done");
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 32'h3F : $urandom;
      cin <= v[5:0];
      repeat (8) @(posedge aclk);
      rd(32'h08, {22'h0, v[5:3], 3'h0, v[2:1], 1'b0, v[0]}, 32'hFFFF_FFFD, 2'h0);
    end
    $display("test status done");
    m = 32'h0;
    for (int i = 0; i < 4; i++) begin
      v = $urandom;
      wr(32'h00, v, 2'h0);
      m = m | (v & 32'h30F);
      rd(32'h0C, m, ALL, 2'h0);
      v = $urandom;
      wr(32'h04, v, 2'h0);
      m = m & ~v;
      rd(32'h0C, m, ALL, 2'h0);
    end
    s_axi_wstrb <= 4'h1;
    wr(32'h00, 32'h30F, 2'h0);
    s_axi_wstrb <= 4'hF;
    wr(32'h104, ALL, 2'h3);
    rd(32'h0C, m | 32'h00F, ALL, 2'h0);
    $display("test mask done");
    cin <= 6'h3F;
    wr(32'h04, ALL, 2'h0);
    repeat (8) @(posedge aclk);
    cmp("irq masked", 32'h0, {31'h0, irq});
    wr(32'h00, 32'h8, 2'h0);
    repeat (2) @(posedge aclk);
    cmp("irq raised", 32'h1, {31'h0, irq});
    cin <= 6'h3B;
    repeat (8) @(posedge aclk);
    rd(32'h10, 32'h8, 32'h8, 2'h0);
    repeat (2) @(posedge aclk);
    cmp("irq cleared", 32'h0, {31'h0, irq});
    $display("test irq done");
    wr(32'h18, 32'h200, 2'h0);
    cmp("pll cfg", 32'h200, pll_first_cfg);
    rd(32'h08, 32'h0, 32'h2, 2'h0);
    repeat (20) @(posedge aclk);
    rd(32'h08, 32'h2, 32'h2, 2'h0);
    wr(32'h14, 32'h1, 2'h0);
    cmp("pump", 32'h1, {30'h0, pump_current_second, pump_current_first});
    $display("test pll done");
    end_of_test();
  end
endmodule : ckirq_tb_top
